// ===== common/cmpfs_defs.svh
`ifndef CMPFS_DEFS_SVH
`define CMPFS_DEFS_SVH

// ----------------------------------------------------------------------
// Register map, word index on the register port
// ----------------------------------------------------------------------
`define CMPFS_PORTS      7
`define CMPFS_K_DATA     2'h0
`define CMPFS_K_DIR      2'h1
`define CMPFS_K_ALT      2'h2
`define CMPFS_A_MODE     6'h1C
`define CMPFS_A_SER      6'h1D
`define CMPFS_A_SER2     6'h1E
`define CMPFS_A_BAUD     6'h1F
`define CMPFS_A_STAT     6'h20

// ----------------------------------------------------------------------
// Port numbers inside the packed pin vectors
// ----------------------------------------------------------------------
`define CMPFS_PA 0
`define CMPFS_PB 1
`define CMPFS_PC 2
`define CMPFS_PD 3
`define CMPFS_PE 4
`define CMPFS_PF 5
`define CMPFS_PG 6

// ----------------------------------------------------------------------
// Fields of MODE, SER and SER2
// ----------------------------------------------------------------------
`define CMPFS_M_PAUSE    1:0
`define CMPFS_M_PBAUX    2
`define CMPFS_M_FSEL     3
`define CMPFS_M_STATUS   5:4
`define CMPFS_M_GPO      6
`define CMPFS_S_CHAR7    0
`define CMPFS_S_NINTH    1
`define CMPFS_S_CLKC     2
`define CMPFS_S_EXTC     3
`define CMPFS_S_CLKD     4
`define CMPFS_S_EXTD     5
`define CMPFS_S_HDLCE    6
`define CMPFS_S_HDLCF    7
`define CMPFS_S2_IRDAE   0
`define CMPFS_S2_IRDAF   1
`define CMPFS_S2_CLKA    2
`define CMPFS_S2_EXTA    3

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define CMPFS_RST_BYTE   8'h00
`define CMPFS_RST_BAUD   8'h08
`define CMPFS_MIN_DIV    8'h08
`define CMPFS_RUN_ADDR   16'h0000
`define CMPFS_CLK_NS     10
`define CMPFS_STRETCH_NS 1000

`endif

// ===== common/cmpfs_pkg.sv
package cmpfs_pkg;

  typedef enum logic [1:0]
  {
    CMPFS_PA_GPIO  = 2'b00,
    CMPFS_PA_EXTIO = 2'b01,
    CMPFS_PA_SLAVE = 2'b10
  } cmpfs_pa_use_t;

  typedef enum logic [1:0]
  {
    CMPFS_ST_FETCH = 2'b00,
    CMPFS_ST_IACK  = 2'b01,
    CMPFS_ST_GPO   = 2'b10
  } cmpfs_status_t;

  typedef enum logic [1:0]
  {
    CMPFS_RS_HOLD   = 2'b00,
    CMPFS_RS_SAMPLE = 2'b01,
    CMPFS_RS_RUN    = 2'b10
  } cmpfs_rst_t;

endpackage

// ===== hdl/cmpfs_sync.sv
module cmpfs_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1;

  // Pins idle high, so both stages start high to avoid false edges.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      stage1 <= '1;
      dout   <= '1;
    end
    else
    begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule // cmpfs_sync

// ===== hdl/cmpfs_top.sv
`include "cmpfs_defs.svh"

module cmpfs_top
  import cmpfs_pkg::*;
(
  input  wire logic            clk_sys,
  input  wire logic            nrst,
  input  wire logic [5:0]      regAddr,
  input  wire logic [7:0]      regWrData,
  input  wire logic            regWr,
  input  wire logic            regRd,
  output logic      [7:0]      regRdData,
  input  wire logic [6:0][7:0] pinIn,
  output logic      [6:0][7:0] pinOut,
  output logic      [6:0][7:0] pinOe,
  input  wire logic            serAClkIn,
  output logic                 serAClkOut,
  output logic                 serAClkOe,
  input  wire logic            serARxdPin,
  output logic                 serATxdPin,
  input  wire logic            bootSelect0,
  input  wire logic            bootSelect1,
  input  wire logic            resetLineIn,
  output logic                 resetLineOut,
  output logic                 resetLineOe,
  output logic                 statusPin,
  output logic                 extIoWriteN,
  output logic                 extIoReadN,
  input  wire logic            coreExtWr,
  input  wire logic            coreExtRd,
  input  wire logic [5:0]      coreExtAddr,
  input  wire logic [7:0]      coreExtWrData,
  output logic      [7:0]      extRdData,
  input  wire logic            firstFetch,
  input  wire logic            intAck,
  output logic                 coreResetReq,
  output logic                 bootColdBoot,
  output logic                 bootRunStart,
  output logic      [15:0]     runStartAddr,
  output logic                 slaveWriteStrobeN,
  output logic                 slaveReadStrobeN,
  output logic      [1:0]      slaveAddr,
  output logic                 slaveSelectN,
  output logic      [7:0]      slaveDataIn,
  input  wire logic [7:0]      slaveDataOut,
  input  wire logic            slaveAttnReq,
  input  wire logic [4:0]      serTx,
  output logic      [4:0]      serRx,
  input  wire logic [2:0]      serClkDrive,
  output logic      [2:0]      shiftTick,
  output logic                 baudTick,
  output logic                 charSeven,
  output logic                 ninthBitEn,
  output logic      [2:0]      clockedMode,
  output logic      [1:0]      hdlcMode,
  output logic      [1:0]      irdaMode,
  output logic                 progLink,
  input  wire logic [2:0][7:0] periphOut,
  input  wire logic [2:0][7:0] periphOe,
  output logic      [2:0][7:0] periphIn
);

  // --------------------------------------------------------------------
  // Constants and helpers
  // --------------------------------------------------------------------
  localparam int STRETCH = (`CMPFS_STRETCH_NS + `CMPFS_CLK_NS - 1) / `CMPFS_CLK_NS;

  function automatic logic isPortReg(input logic [5:0] a, input logic [1:0] k);
    isPortReg = (a[1:0] == k) && (a[5:2] < 4'(`CMPFS_PORTS));
  endfunction

  function automatic logic rise(input logic now, input logic was);
    rise = now && !was;
  endfunction

  // --------------------------------------------------------------------
  // Synchronised pins
  // --------------------------------------------------------------------
  logic [6:0][7:0] pinSync;
  logic [4:0]      miscSync;

  cmpfs_sync #(.WIDTH(61)) uSync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .din     ({pinIn, serAClkIn, serARxdPin, bootSelect0, bootSelect1, resetLineIn}),
    .dout    ({pinSync, miscSync})
  );

  wire clkAPin   = miscSync[4];
  wire rxAPin    = miscSync[3];
  wire bootBoth  = miscSync[2] & miscSync[1];
  wire resetPin  = miscSync[0];

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  logic [6:0][7:0] gpioOut;
  logic [6:0][7:0] gpioDir;
  logic [6:0][7:0] altSel;
  logic [7:0]      modeReg;
  logic [7:0]      serReg;
  logic [7:0]      ser2Reg;
  logic [7:0]      baudReg;

  wire [2:0] wrPort = regAddr[4:2];

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      gpioOut <= '0;
      gpioDir <= '0;
      altSel  <= '0;
      modeReg <= `CMPFS_RST_BYTE;
      serReg  <= `CMPFS_RST_BYTE;
      ser2Reg <= `CMPFS_RST_BYTE;
      baudReg <= `CMPFS_RST_BAUD;
    end
    else if (regWr)
    begin
      if (isPortReg(regAddr, `CMPFS_K_DATA))
        gpioOut[wrPort] <= regWrData;
      if (isPortReg(regAddr, `CMPFS_K_DIR))
        gpioDir[wrPort] <= regWrData;
      if (isPortReg(regAddr, `CMPFS_K_ALT))
        altSel[wrPort] <= regWrData;
      if (regAddr == `CMPFS_A_MODE)
        modeReg <= regWrData;
      if (regAddr == `CMPFS_A_SER)
        serReg <= regWrData;
      if (regAddr == `CMPFS_A_SER2)
        ser2Reg <= regWrData;
      if (regAddr == `CMPFS_A_BAUD)
        baudReg <= regWrData;
    end
  end

  cmpfs_pa_use_t paUse;
  cmpfs_status_t stMode;
  assign paUse  = cmpfs_pa_use_t'(modeReg[`CMPFS_M_PAUSE]);
  assign stMode = cmpfs_status_t'(modeReg[`CMPFS_M_STATUS]);
  wire fSel     = modeReg[`CMPFS_M_FSEL];
  wire pbAux    = modeReg[`CMPFS_M_PBAUX];

  // --------------------------------------------------------------------
  // Reset line and boot mode
  // --------------------------------------------------------------------
  cmpfs_rst_t rstState;
  logic [$clog2(STRETCH+1)-1:0] rstCnt;
  logic bootProg;

  // The line is released before sampling; the wait in SAMPLE also covers
  // a host that keeps the line low after our own pulse ends.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      rstState <= CMPFS_RS_HOLD;
      rstCnt   <= '0;
      bootProg <= 1'b0;
    end
    else
    begin
      unique case (rstState)
        CMPFS_RS_HOLD:
        begin
          rstCnt <= rstCnt + 1'b1;
          if (rstCnt == ($bits(rstCnt))'(STRETCH - 1))
            rstState <= CMPFS_RS_SAMPLE;
        end
        CMPFS_RS_SAMPLE:
        begin
          if (resetPin)
          begin
            bootProg <= bootBoth;
            rstState <= CMPFS_RS_RUN;
          end
        end
        CMPFS_RS_RUN:
        begin
          if (!resetPin)
          begin
            rstCnt   <= '0;
            rstState <= CMPFS_RS_HOLD;
          end
        end
        default: rstState <= CMPFS_RS_HOLD;
      endcase
    end
  end

  wire inHold  = (rstState == CMPFS_RS_HOLD);
  wire toRun   = (rstState == CMPFS_RS_SAMPLE) && resetPin;

  // --------------------------------------------------------------------
  // Baud and clocked-serial timing
  // --------------------------------------------------------------------
  logic [7:0] baudCnt;
  wire  [7:0] baudDiv = (baudReg < `CMPFS_MIN_DIV) ? `CMPFS_MIN_DIV : baudReg;
  wire        baudHit = (baudCnt == 8'h00);

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      baudCnt <= 8'h00;
    else
      baudCnt <= baudHit ? baudDiv - 8'h01 : baudCnt - 8'h01;
  end

  logic [2:0] clkPrev;
  wire  [2:0] clkNow = {pinSync[`CMPFS_PF][0], pinSync[`CMPFS_PF][1], clkAPin};
  wire  [2:0] extClk = {serReg[`CMPFS_S_EXTD], serReg[`CMPFS_S_EXTC], ser2Reg[`CMPFS_S2_EXTA]};
  wire  [2:0] clkOn  = {serReg[`CMPFS_S_CLKD], serReg[`CMPFS_S_CLKC],
                        ser2Reg[`CMPFS_S2_CLKA] & !bootProg};
  wire  [2:0] nextTick;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : gTick
      assign nextTick[gi] = clkOn[gi] & extClk[gi] & rise(clkNow[gi], clkPrev[gi]);
    end
  endgenerate

  // --------------------------------------------------------------------
  // Pin function selection
  // --------------------------------------------------------------------
  wire slvSel  = !pinSync[`CMPFS_PE][7];
  wire slvRd   = !pinSync[`CMPFS_PB][3];
  wire paSlave = (paUse == CMPFS_PA_SLAVE);
  wire paExt   = (paUse == CMPFS_PA_EXTIO);

  logic [6:0][7:0] altOut;
  logic [6:0][7:0] altOe;

  always_comb
  begin
    altOut = '0;
    altOe  = '0;
    // Port A carries external I/O data away from the memory data bus.
    if (paExt)
    begin
      altOut[`CMPFS_PA] = coreExtWrData;
      altOe[`CMPFS_PA]  = {8{coreExtWr}};
    end
    else if (paSlave)
    begin
      altOut[`CMPFS_PA] = slaveDataOut;
      altOe[`CMPFS_PA]  = {8{slvSel & slvRd}};
    end
    if (pbAux)
    begin
      altOut[`CMPFS_PB] = {coreExtAddr[5], 1'b0, coreExtAddr[3:0], 2'b00};
      altOe[`CMPFS_PB]  = 8'hBC;
    end
    else
    begin
      altOut[`CMPFS_PB][7] = !slaveAttnReq;
      altOe[`CMPFS_PB][7]  = 1'b1;
    end
    altOut[`CMPFS_PC] = {4'h0, 1'b0, serTx[1], fSel ? serTx[4] : 1'b0, serTx[2]};
    altOe[`CMPFS_PC]  = {4'h0, 1'b0, 1'b1, fSel, 1'b1};
    altOut[`CMPFS_PD] = periphOut[0];
    altOe[`CMPFS_PD]  = periphOe[0];
    altOut[`CMPFS_PE] = {1'b0, periphOut[1][6:0]};
    altOe[`CMPFS_PE]  = {1'b0, periphOe[1][6:0]};
    altOut[`CMPFS_PF] = periphOut[2];
    altOe[`CMPFS_PF]  = periphOe[2];
    // Internally sourced serial clocks for C and D leave on PF1 and PF0.
    if (clkOn[1] && !extClk[1])
    begin
      altOut[`CMPFS_PF][1] = serClkDrive[1];
      altOe[`CMPFS_PF][1]  = 1'b1;
    end
    if (clkOn[2] && !extClk[2])
    begin
      altOut[`CMPFS_PF][0] = serClkDrive[2];
      altOe[`CMPFS_PF][0]  = 1'b1;
    end
    altOut[`CMPFS_PG] = {1'b0, serTx[3], 6'h00};
    altOe[`CMPFS_PG]  = 8'h40;
  end

  logic [6:0][7:0] nextPinOut;
  logic [6:0][7:0] nextPinOe;
  logic [6:0][7:0] altIn;

  generate
    for (gi = 0; gi < 7; gi++)
    begin : gMux
      assign nextPinOut[gi] = (altSel[gi] & altOut[gi]) | (~altSel[gi] & gpioOut[gi]);
      assign nextPinOe[gi]  = (altSel[gi] & altOe[gi]) | (~altSel[gi] & gpioDir[gi]);
      assign altIn[gi]      = pinSync[gi] & altSel[gi];
    end
  endgenerate

  wire port_c_receive = fSel ? 1'b1 : !altSel[`CMPFS_PC][3] | pinSync[`CMPFS_PC][3];
  wire rxD = fSel ? 1'b1 : !altSel[`CMPFS_PC][1] | pinSync[`CMPFS_PC][1];
  wire port_f_receive = fSel ? !altSel[`CMPFS_PC][3] | pinSync[`CMPFS_PC][3] : 1'b1;
  wire rxE = !altSel[`CMPFS_PG][7] | pinSync[`CMPFS_PG][7];

  wire paAltOn = |altSel[`CMPFS_PA];
  wire slvOn   = paSlave & paAltOn;

  logic nextStatus;
  always_comb
  begin
    unique case (stMode)
      CMPFS_ST_FETCH: nextStatus = !firstFetch;
      CMPFS_ST_IACK:  nextStatus = !intAck;
      CMPFS_ST_GPO:   nextStatus = modeReg[`CMPFS_M_GPO];
      default:        nextStatus = 1'b1;
    endcase
  end

  // --------------------------------------------------------------------
  // Output registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      pinOut      <= '0;
      pinOe       <= '0;
      periphIn    <= '0;
      serRx       <= 5'h1F;
      clkPrev     <= 3'h7;
      shiftTick   <= 3'h0;
      statusPin   <= 1'b1;
      extIoWriteN <= 1'b1;
      extIoReadN  <= 1'b1;
      extRdData   <= 8'h00;
      coreResetReq <= 1'b1;
      bootRunStart <= 1'b0;
      runStartAddr <= `CMPFS_RUN_ADDR;
      slaveWriteStrobeN <= 1'b1;
      slaveReadStrobeN  <= 1'b1;
      slaveSelectN      <= 1'b1;
      slaveAddr         <= 2'h0;
      slaveDataIn       <= 8'h00;
    end
    else
    begin
      pinOut      <= nextPinOut;
      pinOe       <= nextPinOe;
      periphIn    <= {altIn[`CMPFS_PF], altIn[`CMPFS_PE], altIn[`CMPFS_PD]};
      serRx       <= {port_f_receive, rxE, rxD, port_c_receive, rxAPin};
      clkPrev     <= clkNow;
      shiftTick   <= nextTick;
      statusPin   <= nextStatus;
      extIoWriteN <= !coreExtWr;
      extIoReadN  <= !coreExtRd;
      if (paExt && paAltOn && coreExtRd)
        extRdData <= pinSync[`CMPFS_PA];
      coreResetReq <= !(rstState == CMPFS_RS_RUN) && !toRun;
      bootRunStart <= toRun && !bootBoth;
      runStartAddr <= `CMPFS_RUN_ADDR;
      slaveWriteStrobeN <= !(slvOn && !pinSync[`CMPFS_PB][2]);
      slaveReadStrobeN  <= !(slvOn && slvRd);
      slaveSelectN      <= !(slvOn && slvSel);
      slaveAddr         <= slvOn ? pinSync[`CMPFS_PB][5:4] : 2'h0;
      slaveDataIn       <= slvOn ? pinSync[`CMPFS_PA] : 8'h00;
    end
  end

  // --------------------------------------------------------------------
  // Serial port A, reset pin, configuration outputs
  // --------------------------------------------------------------------
  assign serATxdPin   = serTx[0];
  assign serAClkOut   = serClkDrive[0];
  assign serAClkOe    = clkOn[0] & !extClk[0];
  assign resetLineOut = 1'b0;
  assign resetLineOe  = inHold;
  assign bootColdBoot = bootProg;
  assign progLink     = bootProg;
  assign baudTick     = baudHit;
  assign charSeven    = serReg[`CMPFS_S_CHAR7];
  assign ninthBitEn   = serReg[`CMPFS_S_NINTH];
  assign clockedMode  = clkOn;
  assign hdlcMode     = {serReg[`CMPFS_S_HDLCF], serReg[`CMPFS_S_HDLCE]};
  assign irdaMode     = {ser2Reg[`CMPFS_S2_IRDAF], ser2Reg[`CMPFS_S2_IRDAE]} & hdlcMode;

  // --------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------
  wire [7:0] statByte = {4'h0, !resetPin, !clkOn[0] & clkAPin, bootProg, bootProg};

  logic [7:0] rdMux;
  always_comb
  begin
    rdMux = 8'h00;
    if (isPortReg(regAddr, `CMPFS_K_DATA))
      rdMux = pinSync[wrPort];
    else if (isPortReg(regAddr, `CMPFS_K_DIR))
      rdMux = gpioDir[wrPort];
    else if (isPortReg(regAddr, `CMPFS_K_ALT))
      rdMux = altSel[wrPort];
    else if (regAddr == `CMPFS_A_MODE)
      rdMux = modeReg;
    else if (regAddr == `CMPFS_A_SER)
      rdMux = serReg;
    else if (regAddr == `CMPFS_A_SER2)
      rdMux = ser2Reg;
    else if (regAddr == `CMPFS_A_BAUD)
      rdMux = baudReg;
    else if (regAddr == `CMPFS_A_STAT)
      rdMux = statByte;
  end

  // Unmapped reads return zero; data stands only in the cycle after the strobe.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      regRdData <= 8'h00;
    else
      regRdData <= regRd ? rdMux : 8'h00;
  end

endmodule // cmpfs_top

// ===== sim/cmpfs_top_sva.sv
module cmpfs_top_sva
  import cmpfs_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        regRd,
  input wire logic [7:0]  regRdData,
  input wire logic        coreExtWr,
  input wire logic        coreExtRd,
  input wire logic        extIoWriteN,
  input wire logic        extIoReadN,
  input wire logic        resetLineOe,
  input wire logic        resetLineOut,
  input wire logic        coreResetReq,
  input wire logic        bootRunStart,
  input wire logic [15:0] runStartAddr,
  input wire logic        baudTick
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // Pin, read-port and core-interface timing checks
  // ----
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence extWrIssue;
    coreExtWr ##1 !extIoWriteN;
  endsequence
  sequence resetHeld;
    resetLineOe ##1 coreResetReq;
  endsequence
  rd_idle_a: assert property (!$past(regRd) |-> regRdData == 8'h00)
    else $error("read data not zero outside a read");
  wr_strobe_a: assert property (coreExtWr |-> extWrIssue)
    else $error("write strobe missing");
  wr_idle_a: assert property (!coreExtWr |=> extIoWriteN)
    else $error("write strobe without request");
  rd_strobe_a: assert property (coreExtRd |=> !extIoReadN)
    else $error("read strobe missing");
  rd_quiet_a: assert property (!coreExtRd |=> extIoReadN)
    else $error("read strobe without request");
  rst_low_a: assert property (resetLineOe |-> !resetLineOut)
    else $error("reset pin driven high");
  rst_hold_a: assert property (resetLineOe |-> resetHeld)
    else $error("core released while reset pin driven");
  boot_addr_a: assert property (runStartAddr == 16'h0000)
    else $error("run start address not zero");
  run_pulse_a: assert property (bootRunStart |=> !bootRunStart)
    else $error("run start longer than one cycle");
  baud_gap_a: assert property (baudTick |=> !baudTick [*7])
    else $error("baud ticks closer than eight cycles");
endmodule // cmpfs_top_sva

// ===== sim/cmpfs_pin_partner.sv
module cmpfs_pin_partner (
  input wire logic [6:0][7:0] pinOut,
  input wire logic [6:0][7:0] pinOe,
  input wire logic [6:0][7:0] farData,
  input wire logic [6:0][7:0] farOe,
  input wire logic            resetLineOut,
  input wire logic            resetLineOe,
  input wire logic            holdReset,
  input wire logic            progCable,
  input wire logic            clkRun,
  input wire logic            aIdle,
  output logic [6:0][7:0]     pinIn,
  output logic                resetLineIn,
  output logic                bootSelect0,
  output logic                bootSelect1,
  output logic                serAClkIn,
  output logic                linkClk
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // Header pins
  // ----
  initial linkClk = 1'b0;
  always #62.5 linkClk = ~linkClk;
  // Undriven pins sit at their pull-up so a stale value never reads back.
  assign pinIn = (pinOe & pinOut) | (~pinOe & farOe & farData) | (~pinOe & ~farOe);
  assign resetLineIn = ~((resetLineOe & ~resetLineOut) | holdReset);
  assign bootSelect0 = progCable;
  assign bootSelect1 = progCable;
  // The link clock stands still outside frames.
  assign serAClkIn = clkRun ? linkClk : aIdle;
endmodule // cmpfs_pin_partner

// ===== sim/cmpfs_top_tb_top.sv
module cmpfs_top_tb_top
  import cmpfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0, nrst = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic coreExtWr = 1'b0, coreExtRd = 1'b0, firstFetch = 1'b0, intAck = 1'b0;
  logic serARxdPin = 1'b1, slaveAttnReq = 1'b0, holdReset = 1'b0;
  logic progCable = 1'b0, clkRun = 1'b0, aIdle = 1'b1;
  logic [5:0] regAddr = 6'h00, coreExtAddr = 6'h00;
  logic [7:0] regWrData = 8'h00, coreExtWrData = 8'h00, slaveDataOut = 8'h00;
  logic [4:0] serTx = 5'h1F;
  logic [2:0] serClkDrive = 3'h0;
  logic [2:0][7:0] periphOut = 24'h000000, periphOe = 24'h000000, periphIn;
  logic [6:0][7:0] farData = 56'h0, farOe = 56'h0, pinIn, pinOut, pinOe;
  logic [7:0] regRdData, extRdData, slaveDataIn;
  logic [15:0] runStartAddr;
  logic [4:0] serRx;
  logic [2:0] shiftTick, clockedMode;
  logic [1:0] slaveAddr, hdlcMode, irdaMode;
  logic serAClkIn, serAClkOut, serAClkOe, serATxdPin, bootSelect0, bootSelect1, linkClk;
  logic resetLineIn, resetLineOut, resetLineOe, statusPin, extIoWriteN, extIoReadN;
  logic coreResetReq, bootColdBoot, bootRunStart, baudTick, charSeven, ninthBitEn, progLink;
  logic slaveWriteStrobeN, slaveReadStrobeN, slaveSelectN;
  int nFail = 0, numChecks = 0;

  cmpfs_top uut (.clk_sys, .nrst, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .pinIn, .pinOut, .pinOe, .serAClkIn, .serAClkOut, .serAClkOe, .serARxdPin, .serATxdPin,
    .bootSelect0, .bootSelect1, .resetLineIn, .resetLineOut, .resetLineOe, .statusPin,
    .extIoWriteN, .extIoReadN, .coreExtWr, .coreExtRd, .coreExtAddr, .coreExtWrData,
    .extRdData, .firstFetch, .intAck, .coreResetReq, .bootColdBoot, .bootRunStart,
    .runStartAddr, .slaveWriteStrobeN, .slaveReadStrobeN, .slaveAddr, .slaveSelectN,
    .slaveDataIn, .slaveDataOut, .slaveAttnReq, .serTx, .serRx, .serClkDrive, .shiftTick,
    .baudTick, .charSeven, .ninthBitEn, .clockedMode, .hdlcMode, .irdaMode, .progLink,
    .periphOut, .periphOe, .periphIn);
  cmpfs_pin_partner far_i (.pinOut, .pinOe, .farData, .farOe, .resetLineOut, .resetLineOe,
    .holdReset, .progCable, .clkRun, .aIdle, .pinIn, .resetLineIn, .bootSelect0,
    .bootSelect1, .serAClkIn, .linkClk);

  always #5 clk_sys = ~clk_sys;
  // ----
  // Shared tasks
  // ----
  task automatic wrap_up;
    if (nFail == 0 && numChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    numChecks++;
    if (got !== exp)
    begin
      nFail++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 chk(regRdData, e);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_boot(input logic cold);
    int k;
    logic seen;
    k = 0;
    seen = 1'b0;
    chk(resetLineOe, 1'b1);
    while (coreResetReq !== 1'b0 && k < 400)
    begin
      cyc(1);
      k++;
      seen |= (bootRunStart === 1'b1);
    end
    repeat (2)
    begin
      cyc(1);
      seen |= (bootRunStart === 1'b1);
    end
    if (k >= 400)
    begin
      nFail++;
      $display("FAIL t=%0t reset never released", $time);
      wrap_up();
    end
    chk(k >= 97, 1'b1);
    chk(bootColdBoot, cold);
    chk(seen, !cold);
  endtask
  task automatic t_regs;
    rd(6'h1F, 8'h08);
    rd(6'h01, 8'h00);
    rd(6'h3F, 8'h00);
    chk(pinOe, 56'h0);
    wr(6'h01, 8'hFF);
    wr(6'h00, 8'h5A);
    cyc(3);
    chk({pinOe[0], pinOut[0]}, 16'hFF5A);
    rd(6'h00, 8'h5A);
  endtask
  task automatic t_ext;
    wr(6'h1C, 8'h05);
    wr(6'h02, 8'hFF);
    wr(6'h06, 8'hBC);
    cyc(3);
    chk(pinOe[0], 8'h00);
    @(posedge clk_sys);
    coreExtWr <= 1'b1;
    coreExtWrData <= 8'hA5;
    coreExtAddr <= 6'h2A;
    cyc(1);
    chk({extIoWriteN, pinOe[0], pinOut[0]}, 17'h0FFA5);
    cyc(2);
    chk(pinOut[1] & 8'hBC, 8'hA8);
    @(posedge clk_sys);
    coreExtWr <= 1'b0;
    coreExtRd <= 1'b1;
    farData[0] <= 8'h3C;
    farOe[0] <= 8'hFF;
    cyc(5);
    chk({extIoReadN, extRdData}, 9'h03C);
    @(posedge clk_sys);
    coreExtRd <= 1'b0;
  endtask
  task automatic t_slave;
    wr(6'h1C, 8'h02);
    wr(6'h12, 8'h80);
    farData[1] <= 8'h18;
    farOe[1] <= 8'h3C;
    farOe[4] <= 8'h80;
    farData[0] <= 8'h5C;
    slaveAttnReq <= 1'b1;
    cyc(5);
    chk({slaveWriteStrobeN, slaveReadStrobeN, slaveAddr, slaveSelectN}, 5'b01010);
    chk({slaveDataIn, pinOe[1][7], pinOut[1][7]}, 10'h172);
    @(posedge clk_sys);
    farOe <= 56'h0;
    slaveAttnReq <= 1'b0;
  endtask
  task automatic st(input logic [7:0] m, input logic ff, ia, exp);
    wr(6'h1C, m);
    firstFetch <= ff;
    intAck <= ia;
    cyc(3);
    chk(statusPin, exp);
  endtask
  task automatic t_ser;
    int k, cnt;
    cnt = 0;
    wr(6'h1D, 8'hFF);
    wr(6'h1E, 8'h07);
    cyc(2);
    chk({charSeven, ninthBitEn, clockedMode, hdlcMode, irdaMode}, 9'h1FF);
    chk({serAClkOe, serATxdPin, serAClkOut}, 3'b110);
    wr(6'h1E, 8'h0C);
    @(negedge linkClk);
    clkRun = 1'b1;
    fork
      begin
        // Stop in a high phase so that returning to the idle level adds no edge.
        repeat (8) @(posedge linkClk);
        clkRun = 1'b0;
      end
      for (k = 0; k < 130; k++)
      begin
        cyc(1);
        cnt += (shiftTick[0] === 1'b1);
      end
    join
    chk({serAClkOe, cnt[7:0]}, 9'h008);
    wr(6'h1E, 8'h00);
    rd(6'h20, 8'h04);
    aIdle <= 1'b0;
    cyc(4);
    rd(6'h20, 8'h00);
  endtask
  task automatic t_portf;
    wr(6'h1C, 8'h08);
    wr(6'h0A, 8'h0F);
    wr(6'h16, 8'h0F);
    farOe[2] <= 8'h0A;
    cyc(5);
    chk(serRx[4:1], 4'b0111);
    chk(periphIn[2], 8'h0F);
    @(posedge clk_sys);
    farOe[2] <= 8'h00;
  endtask
  task automatic bd(input logic [7:0] b, input int exp);
    int cnt;
    cnt = 0;
    wr(6'h1F, b);
    cyc(16);
    repeat (96)
    begin
      cyc(1);
      cnt += (baudTick === 1'b1);
    end
    chk(cnt, exp);
  endtask
  task automatic t_hostrst;
    @(posedge clk_sys);
    holdReset <= 1'b1;
    progCable <= 1'b1;
    cyc(6);
    chk(coreResetReq, 1'b1);
    @(posedge clk_sys);
    holdReset <= 1'b0;
    cyc(2);
    t_boot(1'b1);
    rd(6'h20, 8'h03);
    wr(6'h1E, 8'h04);
    cyc(2);
    chk({clockedMode[0], serAClkOe, progLink}, 3'b001);
  endtask

  initial
  begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    cyc(1);
    t_boot(1'b0);
    t_regs();
    t_ext();
    t_slave();
    st(8'h60, 1'b0, 1'b0, 1'b1);
    st(8'h20, 1'b0, 1'b0, 1'b0);
    st(8'h00, 1'b1, 1'b0, 1'b0);
    st(8'h10, 1'b0, 1'b1, 1'b0);
    st(8'h10, 1'b0, 1'b0, 1'b1);
    t_ser();
    t_portf();
    bd(8'h03, 12);
    bd(8'h08, 12);
    bd(8'h0C, 8);
    t_hostrst();
    wrap_up();
  end
endmodule // cmpfs_top_tb_top

bind cmpfs_top cmpfs_top_sva chk_i (.clk_sys, .nrst, .regRd, .regRdData, .coreExtWr,
  .coreExtRd, .extIoWriteN, .extIoReadN, .resetLineOe, .resetLineOut, .coreResetReq,
  .bootRunStart, .runStartAddr, .baudTick);
